// ==== hdl/tadc_edge.sv ====
// Serial bus edge, start and stop detector
`default_nettype none
module tadc_edge (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic scl_i, // Bus clock level
    input wire logic sda_i, // Bus data level
    tadc_edge_if.fe eb // Edge events
);
    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } tadc_edge_t;

    tadc_edge_t q;
    tadc_edge_t d;

    always_comb begin
        d.scl = scl_i;
        d.sda = sda_i;
        d.rise = scl_i & ~q.scl;
        d.fall = ~scl_i & q.scl;
        d.start = scl_i & q.scl & q.sda & ~sda_i;
        d.stop = scl_i & q.scl & ~q.sda & sda_i;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign eb.scl_rise = q.rise;
    assign eb.scl_fall = q.fall;
    assign eb.start = q.start;
    assign eb.stop = q.stop;
    assign eb.sda = q.sda;

    start_detect_a: assert property (@(posedge core_clk) disable iff (!rstn)
        q.start |-> q.scl && !q.sda && $past(q.sda)) else $error("false start");
endmodule
`default_nettype wire

// ==== hdl/tadc_i2c_cmd_readout.sv ====
// Touch converter serial-bus slave: command write, acquisition control, result read
//
// What this block does; R8 is left to the bus master
// R1: Acknowledge write address only on match
// R2: Acknowledge one command byte, then STOP/Sr
// R3: Never acknowledge further command bytes
// R4: Channel on fourth bit; drivers at acquisition
// R5: Sample from last function bit fall to STOP/Sr
// R6: Convert after acquisition; mux disconnected
// R7: Position drivers stay on during conversion
// R8: Master should idle 10 us before reading
// R9: Read address acked, then result bits 11-4
// R10: Release for master ack, then bits 3-0
// R11: Master ack of last byte yields FFh
// R12: Op takes 19 or 16 conversion clocks
// R13: 12-bit: seven ops plus filter, overlap four
// R14: 8-bit: seven 16-clock ops plus filter
// R15: 12-bit read cycle carries two bytes
// R16: 8-bit read cycle carries one byte
// R17: Address is fixed five bits plus pins
// R18: Command fields: function, power-down, resolution
// R19: Resolution bit: 0 twelve-bit, 1 eight-bit
// R20: Result register replaced only on completion
`default_nettype none
module tadc_i2c_cmd_readout (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic scl_i, // Bus clock
    input wire logic sda_i, // Bus data level
    output logic sda_o, // Bus data drive value, always low
    output logic sda_oe, // High while pulling data low
    input wire logic [1:0] address_select_pins, // Low address bits
    input wire logic [11:0] adc_data_i, // Converter code
    output logic [3:0] function_select_o, // Selected function and channel
    output logic [1:0] power_down_select_o, // Power-down mode
    output logic [3:0] panel_drv_o, // Drivers {xp, xn, yp, yn}
    output logic mux_connect_o, // Input mux connected to converter
    output logic adc_sample_o, // One-cycle pulse per sample
    output logic conv_done_o // One-cycle pulse on new result
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tadc_pkg::tadc_bus_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic oe;
        logic sda_drv;
        logic [3:0] func;
        logic [1:0] pd;
        logic mode8;
        logic acq;
        logic acq_start;
        logic acq_end;
        logic mack;
        logic byte_no;
        logic [11:0] res;
        logic done;
    } tadc_main_t;

    tadc_main_t q;
    tadc_main_t d;
    logic [7:0] next_byte;

    // ----------------------------------------------------------------
    // Sub-blocks; the sequencer runs on its own tick, not the bus clock
    // ----------------------------------------------------------------
    tadc_edge_if eb();
    tadc_cvt_if cv();

    tadc_edge u_edge (
        .core_clk(core_clk),
        .rstn(rstn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .eb(eb)
    );

    tadc_seq u_seq (
        .core_clk(core_clk),
        .rstn(rstn),
        .cv(cv)
    );

    assign cv.acq_start = q.acq_start;
    assign cv.acq_end = q.acq_end;
    assign cv.mode8 = q.mode8;
    assign cv.pd0 = q.pd[0];
    assign cv.func = q.func;
    assign cv.adc_data = adc_data_i;

    // ----------------------------------------------------------------
    // Bus protocol
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.acq_start = 1'b0;
        d.acq_end = 1'b0;
        d.done = cv.done;
        // Second read byte exists only in 12-bit mode
        next_byte = (!q.byte_no && !q.mode8) ? {q.res[3:0], 4'h0} // [R10] [R15]
                                              : tadc_pkg::INVALID_BYTE; // [R11] [R16]
        if (cv.done) begin
            d.res = cv.result; // [R20]
        end
        if (eb.start || eb.stop) begin
            if (q.acq) begin
                d.acq = 1'b0;
                d.acq_end = 1'b1; // [R5] [R2]
            end
            d.oe = 1'b0;
            d.cnt = 4'h0;
            d.st = eb.start ? tadc_pkg::BUS_ADDR : tadc_pkg::BUS_IDLE;
        end else begin
            // While sending, this shift also brings up the next bit
            if (eb.scl_rise) begin
                d.sh = {q.sh[6:0], eb.sda};
                d.cnt = 4'(q.cnt + 4'h1);
            end
            case (q.st)
                tadc_pkg::BUS_IDLE: begin
                    d.oe = 1'b0;
                end
                tadc_pkg::BUS_ADDR: begin
                    if (eb.scl_fall && q.cnt == tadc_pkg::CNT_BYTE) begin
                        d.cnt = 4'h0;
                        if (q.sh[7:1] == {tadc_pkg::ADDR_FIXED, address_select_pins}) begin // [R17]
                            d.oe = 1'b1; // [R1] [R9]
                            d.rw = q.sh[0];
                            d.st = tadc_pkg::BUS_ADDR_ACK;
                        end else begin
                            d.st = tadc_pkg::BUS_IDLE;
                        end
                    end
                end
                tadc_pkg::BUS_ADDR_ACK: begin
                    if (eb.scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.rw) begin
                            d.sh = q.res[11:4]; // [R9]
                            d.oe = ~q.res[11];
                            d.byte_no = 1'b0;
                            d.st = tadc_pkg::BUS_TX;
                        end else begin
                            d.oe = 1'b0;
                            d.st = tadc_pkg::BUS_CMD;
                        end
                    end
                end
                tadc_pkg::BUS_CMD: begin
                    if (eb.scl_rise && q.cnt == 4'(tadc_pkg::CNT_FUNC - 4'h1)) begin
                        d.func = {q.sh[2:0], eb.sda}; // [R4] [R18]
                    end
                    if (eb.scl_fall && q.cnt == tadc_pkg::CNT_FUNC) begin
                        d.acq = 1'b1; // [R5]
                        d.acq_start = 1'b1;
                    end
                    if (eb.scl_fall && q.cnt == tadc_pkg::CNT_BYTE) begin
                        d.pd = q.sh[tadc_pkg::CMD_PD_LSB +: 2]; // [R18]
                        d.mode8 = q.sh[tadc_pkg::CMD_MODE_BIT]; // [R19]
                        d.oe = 1'b1; // [R2]
                        d.st = tadc_pkg::BUS_CMD_ACK;
                    end
                end
                tadc_pkg::BUS_CMD_ACK: begin
                    if (eb.scl_fall) begin
                        d.oe = 1'b0;
                        d.cnt = 4'h0;
                        d.st = tadc_pkg::BUS_EXTRA;
                    end
                end
                tadc_pkg::BUS_EXTRA: begin
                    // Extra bytes are clocked through with no acknowledge
                    d.oe = 1'b0; // [R3]
                    if (eb.scl_fall && q.cnt == tadc_pkg::CNT_SLOT) begin
                        d.cnt = 4'h0;
                    end
                end
                tadc_pkg::BUS_TX: begin
                    if (eb.scl_fall) begin
                        if (q.cnt == tadc_pkg::CNT_BYTE) begin
                            d.oe = 1'b0; // [R10]
                            d.st = tadc_pkg::BUS_TX_ACK;
                        end else begin
                            d.oe = ~q.sh[7];
                        end
                    end
                end
                tadc_pkg::BUS_TX_ACK: begin
                    if (eb.scl_rise) begin
                        d.mack = ~eb.sda;
                    end
                    if (eb.scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.mack) begin
                            d.sh = next_byte; // [R10] [R11]
                            d.oe = ~next_byte[7];
                            d.byte_no = 1'b1;
                            d.st = tadc_pkg::BUS_TX;
                        end else begin
                            d.oe = 1'b0;
                            d.st = tadc_pkg::BUS_IDLE;
                        end
                    end
                end
                default: begin
                    d.st = tadc_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: tadc_pkg::BUS_IDLE, func: tadc_pkg::FUNC_RST, pd: tadc_pkg::PD_RST,
                   res: tadc_pkg::RESULT_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sda_o = q.sda_drv;
    assign sda_oe = q.oe;
    assign function_select_o = q.func;
    assign power_down_select_o = q.pd;
    assign panel_drv_o = cv.drv;
    assign mux_connect_o = cv.mux;
    assign adc_sample_o = cv.sample;
    assign conv_done_o = q.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence addr_done_s;
        q.st == tadc_pkg::BUS_ADDR && eb.scl_fall && q.cnt == tadc_pkg::CNT_BYTE;
    endsequence
    sequence func_done_s;
        q.st == tadc_pkg::BUS_CMD && eb.scl_fall && q.cnt == tadc_pkg::CNT_FUNC;
    endsequence
    sequence cmd_done_s;
        q.st == tadc_pkg::BUS_CMD && eb.scl_fall && q.cnt == tadc_pkg::CNT_BYTE;
    endsequence
    sequence tx_done_s;
        q.st == tadc_pkg::BUS_TX && eb.scl_fall && q.cnt == tadc_pkg::CNT_BYTE;
    endsequence
    sequence second_ack_s;
        q.st == tadc_pkg::BUS_TX_ACK && eb.scl_fall && q.mack && !q.byte_no && !q.mode8;
    endsequence
    sequence last_ack_s;
        q.st == tadc_pkg::BUS_TX_ACK && eb.scl_fall && q.mack && (q.byte_no || q.mode8);
    endsequence

    addr_ack_match_a: assert property ( // [R1]
        addr_done_s and (q.sh[7:1] == {tadc_pkg::ADDR_FIXED, address_select_pins})
        |=> q.oe && q.st == tadc_pkg::BUS_ADDR_ACK) else $error("address not acked");
    addr_nomatch_a: assert property ( // [R17]
        addr_done_s and (q.sh[7:1] != {tadc_pkg::ADDR_FIXED, address_select_pins})
        |=> !q.oe && q.st == tadc_pkg::BUS_IDLE) else $error("foreign address acked");
    cmd_ack_a: assert property ( // [R2]
        cmd_done_s |=> q.oe && q.st == tadc_pkg::BUS_CMD_ACK)
        else $error("command not acked");
    cmd_fields_a: assert property ( // [R18] [R19]
        cmd_done_s |=> q.pd == $past(q.sh[3:2]) && q.mode8 == $past(q.sh[1]))
        else $error("command fields not latched");
    extra_no_ack_a: assert property (q.st == tadc_pkg::BUS_EXTRA |-> !q.oe) // [R3]
        else $error("extra command byte acked");
    chan_select_a: assert property (q.st == tadc_pkg::BUS_CMD && eb.scl_rise // [R4]
        && q.cnt == 4'h3 |=> q.func == {$past(q.sh[2:0]), $past(eb.sda)})
        else $error("channel not selected");
    acq_begin_a: assert property (func_done_s |=> q.acq_start ##1 cv.mux) // [R5]
        else $error("acquisition did not start");
    acq_end_a: assert property (q.acq && (eb.start || eb.stop) // [R6]
        |=> q.acq_end && !q.acq ##1 !cv.mux) else $error("acquisition did not end");
    tx_msb_a: assert property (q.st == tadc_pkg::BUS_ADDR_ACK && q.rw && eb.scl_fall // [R9]
        |=> q.oe == ~$past(q.res[11]) && q.st == tadc_pkg::BUS_TX)
        else $error("wrong first data bit");
    tx_bit_a: assert property ( // [R9] [R10]
        q.st == tadc_pkg::BUS_TX && eb.scl_fall && q.cnt != tadc_pkg::CNT_BYTE
        |=> q.oe == ~$past(q.sh[7])) else $error("wrong data bit driven");
    tx_release_a: assert property (tx_done_s // [R10]
        |=> !q.oe && q.st == tadc_pkg::BUS_TX_ACK) else $error("data line not released");
    second_byte_a: assert property ( // [R10]
        second_ack_s |=> q.sh == {$past(q.res[3:0]), 4'h0} && q.oe == ~$past(q.res[3]))
        else $error("wrong second data byte");
    invalid_ff_a: assert property (last_ack_s |=> q.sh == tadc_pkg::INVALID_BYTE) // [R11]
        else $error("invalid byte not all ones");
    read_end_a: assert property ( // [R11]
        q.st == tadc_pkg::BUS_TX_ACK && eb.scl_fall && !q.mack
        |=> !q.oe && q.st == tadc_pkg::BUS_IDLE) else $error("read not ended on nack");
    result_hold_a: assert property (!cv.done |=> $stable(q.res)) // [R20]
        else $error("result changed without conversion");
    result_load_a: assert property (cv.done |=> q.res == $past(cv.result)) // [R20]
        else $error("result not loaded on completion");
endmodule
`default_nettype wire

// ==== hdl/tadc_ifs.sv ====
// Interfaces between the bus controller, its edge detector and the sequencer
`default_nettype none
interface tadc_edge_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    modport fe(output scl_rise, scl_fall, start, stop, sda);
    modport ctl(input scl_rise, scl_fall, start, stop, sda);
endinterface

interface tadc_cvt_if;
    logic acq_start;
    logic acq_end;
    logic mode8;
    logic pd0;
    logic [3:0] func;
    logic [11:0] adc_data;
    logic done;
    logic [11:0] result;
    logic [3:0] drv;
    logic mux;
    logic sample;
    modport ctl(output acq_start, acq_end, mode8, pd0, func, adc_data,
                input done, result, drv, mux, sample);
    modport seq(input acq_start, acq_end, mode8, pd0, func, adc_data,
                output done, result, drv, mux, sample);
endinterface
`default_nettype wire

// ==== hdl/tadc_pkg.sv ====
// Shared constants and types of the touch converter bus and conversion logic
`default_nettype none
package tadc_pkg;
    // Bus address and byte framing
    localparam logic [4:0] ADDR_FIXED = 5'h12;
    localparam logic [3:0] CNT_FUNC = 4'h4;
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_SLOT = 4'h9;
    localparam logic [7:0] INVALID_BYTE = 8'hFF;
    localparam int CMD_PD_LSB = 2;
    localparam int CMD_MODE_BIT = 1;
    // Conversion clock derived from the core clock
    localparam int CORE_CLK_HZ = 100_000_000;
    localparam int CONV_HZ = 4_000_000;
    localparam logic [4:0] TICK_DIV = 5'(CORE_CLK_HZ / CONV_HZ);
    localparam logic [4:0] OP_TICKS_12 = 5'h13;
    localparam logic [4:0] OP_TICKS_8 = 5'h10;
    localparam logic [4:0] FILT_TICKS = 5'h13;
    localparam logic [4:0] OVERLAP_TICKS = 5'h04;
    localparam logic [2:0] OPS = 3'h7;
    localparam logic [2:0] FILT_FIRST_OP = 3'h3;
    // Panel drivers {xp, xn, yp, yn}
    localparam logic [1:0] FUNC_POS = 2'h3;
    localparam logic [3:0] DRV_X = 4'hC;
    localparam logic [3:0] DRV_Y = 4'h3;
    localparam logic [3:0] DRV_Z = 4'h6;
    // Reset values
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [3:0] FUNC_RST = 4'h0;
    localparam logic [1:0] PD_RST = 2'h0;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_CMD = 3'b011,
        BUS_CMD_ACK = 3'b100,
        BUS_EXTRA = 3'b101,
        BUS_TX = 3'b110,
        BUS_TX_ACK = 3'b111
    } tadc_bus_st_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ACQ = 2'b01,
        SEQ_CONV = 2'b10,
        SEQ_FILT = 2'b11
    } tadc_seq_st_t;
endpackage
`default_nettype wire

// ==== hdl/tadc_seq.sv ====
// Acquisition, conversion and filter sequencer on the conversion clock tick
`default_nettype none
module tadc_seq (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rstn, // Async reset, active low
    tadc_cvt_if.seq cv // Sequencer side
);
    typedef struct packed {
        tadc_pkg::tadc_seq_st_t st;
        logic [4:0] div;
        logic [4:0] ph;
        logic [2:0] op;
        logic [13:0] acc;
        logic [3:0] drv;
        logic mux;
        logic samp;
        logic done;
        logic [11:0] res;
    } tadc_seq_s_t;

    tadc_seq_s_t q;
    tadc_seq_s_t d;
    logic tick;
    logic [4:0] op_len;

    always_comb begin
        d = q;
        d.samp = 1'b0;
        d.done = 1'b0;
        tick = (q.div == 5'(tadc_pkg::TICK_DIV - 5'h01));
        op_len = cv.mode8 ? tadc_pkg::OP_TICKS_8 : tadc_pkg::OP_TICKS_12; // [R12] [R19]
        if (q.st == tadc_pkg::SEQ_CONV || q.st == tadc_pkg::SEQ_FILT) begin
            d.div = tick ? 5'h00 : 5'(q.div + 5'h01);
        end
        if (cv.acq_start) begin
            d.st = tadc_pkg::SEQ_ACQ;
            d.mux = 1'b1;
            d.acc = '0;
            if (cv.func[3:2] == tadc_pkg::FUNC_POS) begin // [R4]
                case (cv.func[1:0])
                    2'h0: d.drv = tadc_pkg::DRV_X;
                    2'h1: d.drv = tadc_pkg::DRV_Y;
                    default: d.drv = tadc_pkg::DRV_Z;
                endcase
            end else begin
                d.drv = 4'h0;
            end
        end else begin
            case (q.st)
                tadc_pkg::SEQ_ACQ: if (cv.acq_end) begin
                    d.st = tadc_pkg::SEQ_CONV; // [R6]
                    d.mux = 1'b0;
                    d.div = 5'h00;
                    d.op = 3'h0;
                    // First op's front overlaps the bus transfer
                    d.ph = tadc_pkg::OVERLAP_TICKS; // [R13] [R14]
                end
                tadc_pkg::SEQ_CONV: if (tick) begin
                    d.ph = 5'(q.ph + 5'h01);
                    if (q.ph == 5'(op_len - 5'h01)) begin // [R12]
                        d.samp = 1'b1;
                        d.ph = 5'h00;
                        d.op = 3'(q.op + 3'h1);
                        if (q.op >= tadc_pkg::FILT_FIRST_OP) begin
                            d.acc = 14'(q.acc + {2'h0, cv.adc_data});
                        end
                        if (q.op == 3'(tadc_pkg::OPS - 3'h1)) begin
                            d.st = tadc_pkg::SEQ_FILT;
                        end
                    end
                end
                tadc_pkg::SEQ_FILT: if (tick) begin
                    d.ph = 5'(q.ph + 5'h01);
                    if (q.ph == 5'(tadc_pkg::FILT_TICKS - 5'h01)) begin // [R13] [R14]
                        d.st = tadc_pkg::SEQ_IDLE;
                        d.done = 1'b1;
                        d.res = cv.mode8 ? {q.acc[13:6], 4'h0} : q.acc[13:2];
                        // Drivers stay on after the cycle only if asked
                        d.drv = cv.pd0 ? q.drv : 4'h0; // [R7]
                    end
                end
                default: d.st = q.st;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: tadc_pkg::SEQ_IDLE, res: tadc_pkg::RESULT_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    assign cv.done = q.done;
    assign cv.result = q.res;
    assign cv.drv = q.drv;
    assign cv.mux = q.mux;
    assign cv.sample = q.samp;

    logic [7:0] tcnt_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tcnt_q <= 8'h00;
        end else if (cv.acq_end) begin
            tcnt_q <= 8'h00;
        end else if (tick && q.st != tadc_pkg::SEQ_IDLE && q.st != tadc_pkg::SEQ_ACQ) begin
            tcnt_q <= 8'(tcnt_q + 8'h01);
        end
    end

    mux_off_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R6]
        q.st == tadc_pkg::SEQ_CONV || q.st == tadc_pkg::SEQ_FILT |-> !q.mux)
        else $error("mux connected during conversion");
    drv_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R7]
        q.st == tadc_pkg::SEQ_CONV && !cv.acq_start |=> $stable(q.drv))
        else $error("drivers changed during conversion");
    conv_len_a: assert property (@(posedge core_clk) disable iff (!rstn) // [R13] [R14]
        q.done |-> tcnt_q == 8'(tadc_pkg::OPS * op_len + tadc_pkg::FILT_TICKS
        - tadc_pkg::OVERLAP_TICKS)) else $error("wrong conversion length");
endmodule
`default_nettype wire

// ==== verif/tadc_i2c_cmd_readout_tb.sv ====
// Self-checking bench: command writes, conversion timing and result reads
`default_nettype none
module tadc_i2c_cmd_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] pins = 2'h0;
    logic [11:0] adc = 12'h000;
    logic scl, sda_m, sda_o, sda_oe, mux, samp, done, sda_w;
    logic [3:0] func, drv;
    logic [1:0] pd;
    int failures = 0;
    int checks = 0;
    int n_samp = 0;
    int cyc_now = 0;
    assign sda_w = sda_m & ~(sda_oe & ~sda_o);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc_now <= cyc_now + 1;
        if (samp === 1'b1) n_samp <= n_samp + 1;
    end
    tadc_master_model m (.core_clk(core_clk), .sda_w(sda_w), .scl_o(scl), .sda_m(sda_m));
    tadc_i2c_cmd_readout DUT (.core_clk(core_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pins(pins), .adc_data_i(adc),
        .function_select_o(func), .power_down_select_o(pd), .panel_drv_o(drv),
        .mux_connect_o(mux), .adc_sample_o(samp), .conv_done_o(done));
    function automatic logic [3:0] exp_drv(input logic [3:0] f);
        case (f)
            4'hC: return tadc_pkg::DRV_X;
            4'hD: return tadc_pkg::DRV_Y;
            4'hE, 4'hF: return tadc_pkg::DRV_Z;
            default: return 4'h0;
        endcase
    endfunction
    // Constant input, so the mean of four samples is the input itself
    function automatic logic [11:0] exp_res(input logic [11:0] v, input logic m8);
        return m8 ? {v[11:4], 4'h0} : v;
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd(input logic m8, input logic [11:0] e);
        logic [7:0] q;
        logic a;
        m.start();
        m.xfer({tadc_pkg::ADDR_FIXED, pins, 1'b1}, 1'b1, q, a);
        chk(12'(a), 12'h1);
        m.xfer(8'hFF, 1'b0, q, a);
        chk(12'(q), 12'(e[11:4]));
        if (!m8) begin
            m.xfer(8'hFF, 1'b0, q, a);
            chk(12'(q), {4'h0, e[3:0], 4'h0});
        end
        m.xfer(8'hFF, 1'b1, q, a);
        chk(12'(q), 12'(tadc_pkg::INVALID_BYTE));
        m.stop();
    endtask
    initial begin
        logic [7:0] q;
        logic a, m8;
        logic [3:0] f;
        logic [1:0] p;
        logic [11:0] prev;
        int base, t0, cyc, el, tk;
        void'($urandom(32'h1fc8));
        prev = tadc_pkg::RESULT_RST;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        pins <= 2'($urandom());
        @(posedge core_clk);
        m.start();
        m.xfer({tadc_pkg::ADDR_FIXED, ~pins, 1'b0}, 1'b1, q, a);
        chk(12'(a), 12'h0);
        m.stop();
        for (int i = 0; i < 5; i++) begin
            f = (i == 4) ? 4'h2 : 4'hC + 4'(i);
            m8 = i[0];
            p = 2'($urandom());
            adc <= 12'($urandom());
            m.start();
            m.xfer({tadc_pkg::ADDR_FIXED, pins, 1'b0}, 1'b1, q, a);
            chk(12'(a), 12'h1);
            chk(12'(sda_o), 12'h0);
            m.xfer({f, p, m8, 1'($urandom())}, 1'b1, q, a);
            chk(12'(a), 12'h1);
            chk(12'(func), 12'(f));
            chk(12'(pd), 12'(p));
            chk(12'(drv), 12'(exp_drv(f)));
            m.xfer(8'($urandom()), 1'b1, q, a);
            chk(12'(a), 12'h0);
            chk(12'(mux), 12'h1);
            base = n_samp;
            if (i[1]) m.start();
            else m.stop();
            t0 = cyc_now;
            chk(12'(mux), 12'h0);
            chk(12'(drv), 12'(exp_drv(f)));
            rd(m8, exp_res(prev, m8));
            // Bus kept idle until the result, well past the settling wait
            for (cyc = 0; cyc < 6000 && done !== 1'b1; cyc++) @(posedge core_clk);
            if (cyc == 6000) begin
                failures++;
                close_out();
            end
            // Tick phase is unknown, so allow two ticks either way
            el = cyc_now - t0;
            tk = m8 ? 127 : 148;
            el = (el >= tk * 25 - 50 && el <= tk * 25 + 50) ? tk : el / 25;
            chk(12'(el), 12'(tk));
            chk(12'(n_samp - base), 12'h7);
            chk(12'(drv), p[0] ? 12'(exp_drv(f)) : 12'h000);
            prev = exp_res(adc, m8);
            rd(m8, prev);
        end
        close_out();
    end
endmodule
`default_nettype wire

// ==== verif/tadc_master_model.sv ====
// Open-drain bus master model, paced by the core clock
`default_nettype none
module tadc_master_model (
    input wire logic core_clk, // Core clock
    input wire logic sda_w, // Resolved data wire
    output logic scl_o, // Bus clock drive
    output logic sda_m // Data drive, 1 releases to pull-up
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        sda_m = 1'b1;
    end
    // Five cycles a half period, above the detector minimum of three
    task automatic half();
        repeat (5) @(posedge core_clk);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_m <= 1'b0;
        half();
        scl_o <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_m <= 1'b1;
        half();
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_m <= b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_w;
        scl_o <= 1'b0;
        half();
    endtask
    // Byte then ack slot; master acks with ack_m low, else releases
    task automatic xfer(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
                        output logic ack_s);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(ack_m, r);
        ack_s = ~r;
    endtask
endmodule
`default_nettype wire
